// ### lio_in_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Pins are asynchronous to aclk
// Notes:   Only stage two and three are ever looked at together
`timescale 1ns/1ps
module lio_in_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw pins
    input wire logic [lio_pkg::SYNC_W-1:0] pin_in,
    // Filtered level and change pulse
    output logic [lio_pkg::SYNC_W-1:0] level,
    output logic [lio_pkg::SYNC_W-1:0] change
);

    // ==========================================================
    // Synchroniser stages
    logic [lio_pkg::SYNC_W-1:0] s1_ff;
    logic [lio_pkg::SYNC_W-1:0] s2_ff;
    logic [lio_pkg::SYNC_W-1:0] s3_ff;
    logic [lio_pkg::SYNC_W-1:0] lvl_ff;
    logic [lio_pkg::SYNC_W-1:0] chg_ff;
    logic [lio_pkg::SYNC_W-1:0] agree;
    logic [lio_pkg::SYNC_W-1:0] nxt_lvl;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A change is taken only once stage two and three agree
    always_comb begin
        agree = ~(s2_ff ^ s3_ff);
        nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_ff <= '0;
            chg_ff <= '0;
        end else begin
            lvl_ff <= nxt_lvl;
            chg_ff <= nxt_lvl ^ lvl_ff;
        end
    end

    assign level = lvl_ff;
    assign change = chg_ff;

endmodule // lio_in_sync

// ### lio_partner.sv
// Purpose: Link and sibling-module stand-in for the I/O bench
// Assumes: Monitor values are same-clock levels
// Notes: Unselected sources read zero so a wrong selection shows
`timescale 1ns/1ps
module lio_partner (
    // Bench commands
    input wire logic drop,
    input wire logic [1:0] sel,
    input wire logic [31:0] val,
    // Toward the module
    output logic link_alive,
    output logic [31:0] mon_pulse,
    output logic [31:0] mon_analog,
    output logic [31:0] mon_encoder
);
    assign link_alive = !drop;
    assign mon_pulse = (sel == 2'h1) ? val : 32'h0;
    assign mon_analog = (sel == 2'h2) ? val : 32'h0;
    assign mon_encoder = (sel == 2'h3) ? val : 32'h0;
endmodule // lio_partner

// ### lio_pkg.sv
// Purpose: Shared constants and types of the latching digital I/O module
// Assumes: 40 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   Byte offsets below are word aligned
package lio_pkg;

    // ==========================================================
    // Widths and timing
    localparam int CLK_MHZ = 40;
    localparam int ADDR_W = 8;
    localparam int DIN_W = 16;
    localparam int SYNC_W = 17;
    localparam int CNT_W = 24;
    // Cycles spent in the three-stage input synchroniser
    localparam logic [31:0] SYNC_LAG = 32'h0000_0003;
    localparam int WDOG_MS = 100;
    localparam int WDOG_CYC = WDOG_MS * CLK_MHZ * 1000;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIN = 8'h04;
    localparam logic [7:0] OFS_DOUT = 8'h08;
    localparam logic [7:0] OFS_LVL_EN = 8'h0c;
    localparam logic [7:0] OFS_LVL_SRC = 8'h10;
    localparam logic [7:0] OFS_THR_PULSE = 8'h14;
    localparam logic [7:0] OFS_THR_ANALOG = 8'h18;
    localparam logic [7:0] OFS_THR_ENC = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [7:0] OFS_MASK = 8'h24;
    localparam logic [7:0] OFS_TIME = 8'h28;
    localparam logic [7:0] OFS_WDOG = 8'h2c;
    localparam logic [7:0] OFS_STAMP = 8'h40;
    localparam logic [1:0] STAMP_SEL = 2'h1;

    localparam int STAT_LINK = 16;
    localparam int STAT_WDOG = 17;
    localparam int STAT_W = 18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    typedef struct packed {
        logic wdog_en;
        logic alarm;
        logic warn;
        logic hold;
        logic init_done;
    } lio_ctrl_t;

    typedef struct packed {
        logic green;
        logic red;
    } lio_led_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_PULSE = 2'h1,
        SRC_ANALOG = 2'h2,
        SRC_ENC = 2'h3
    } lio_src_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_RUN = 3'h2,
        ST_WDOG = 3'h4
    } lio_state_t;

endpackage

// ### lio_sva.sv
// Purpose: Port assertions for the digital I/O module
// Assumes: One aclk domain, reset synchronous active low
// Notes: LED value is {green, red}, so 2'b01 is red
`timescale 1ns/1ps
module lio_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Indicators
    input wire lio_pkg::lio_led_t run_led,
    input wire lio_pkg::lio_led_t err_led
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late bvalid");
    rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("late rvalid");
    b_close_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
        && s_axi_awready && s_axi_wready) else $error("bvalid stuck");
    r_close_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    wr_busy_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready during response");
    wdog_hold_a:
    assert property (run_led == 2'b01 |=> run_led == 2'b01
        && err_led == 2'b01) else $error("watchdog lost");
    init_pair_a:
    assert property (run_led == 2'b11 |-> err_led == 2'b11)
        else $error("orange not paired");
    err_color_a:
    assert property (err_led != 2'b10) else $error("error led green");
endmodule // lio_sva

bind lio_top lio_sva i_lio_sva (.*);

// ### lio_top.sv
// Purpose: Latching digital I/O module, sixteen inputs, sixteen outputs
// Assumes: Controller reaches the registers over AXI4-Lite
// Notes:   Level outputs run without the controller
//
// How it works
// - Each input line is synchronised and its state is readable.
// - Software sets each output on or off and the pin follows it.
// - Any input change stores the time stamp of that change.
// - All sixteen input lines have their own time capture.
// - Stamps have 25 ns resolution, corrected for synchroniser lag.
// - Outputs in level mode follow a monitor value against a threshold.
// - On link loss commanded outputs are held or cleared by selection.
// - Run indicator is green in run when powered properly, orange in init.
// - Run indicator is dark when power is not good, except after watchdog expiry.
// - Error indicator flashes red on warning, steady red on alarm.
// - Error indicator is dark in normal operation.
// - Both indicators are orange until init finishes.
// - Watchdog expiry lights both indicators steady red.
`timescale 1ns/1ps
module lio_top #(
    parameter logic [lio_pkg::CNT_W-1:0] WDOG_CYC =
        lio_pkg::CNT_W'(lio_pkg::WDOG_CYC),
    parameter logic [lio_pkg::CNT_W-1:0] BLINK_CYC =
        lio_pkg::CNT_W'(lio_pkg::BLINK_CYC)
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [lio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [lio_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and link state
    input wire logic [lio_pkg::DIN_W-1:0] input_line,
    input wire logic power_good,
    input wire logic link_alive,
    // Sibling monitor values
    input wire logic [31:0] mon_pulse,
    input wire logic [31:0] mon_analog,
    input wire logic [31:0] mon_encoder,
    // Outputs
    output logic [lio_pkg::DIN_W-1:0] output_line,
    output lio_pkg::lio_led_t run_led,
    output lio_pkg::lio_led_t err_led,
    output logic irq
);

    // ==========================================================
    // Functions
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic at_level(input logic [31:0] mon,
                                      input logic [31:0] thr);
        return $signed(mon) >= $signed(thr);
    endfunction

    // ==========================================================
    // Declarations
    logic aw_hold_ff, w_hold_ff, bvalid_ff, awready_ff, wready_ff;
    logic arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, wdata_ff;
    logic [3:0] wstrb_ff;
    logic [lio_pkg::ADDR_W-1:0] awaddr_ff;
    logic wr_go, wr_ok, rd_ok, ar_take, aw_take, w_take;
    logic nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
    logic [31:0] rd_word, nxt_dout, nxt_mask, nxt_lvl_en, nxt_ctrl;
    logic [31:0] stat_clr;
    lio_pkg::lio_ctrl_t ctrl_ff;
    logic [lio_pkg::DIN_W-1:0] dout_ff, lvl_en_ff, out_ff, nxt_out;
    logic [lio_pkg::DIN_W-1:0] lvl_hit, cmd_eff, din_chg;
    logic [31:0] lvl_src_ff, thr_pulse_ff, thr_analog_ff, thr_enc_ff;
    logic [lio_pkg::STAT_W-1:0] stat_ff, mask_ff, stat_set;
    logic [31:0] time_ff;
    logic [31:0] stamp_ff [lio_pkg::DIN_W];
    logic [lio_pkg::SYNC_W-1:0] sync_lvl, sync_chg;
    logic link_ff, link_fall, wdog_fire, blink_ff, irq_ff;
    logic [lio_pkg::CNT_W-1:0] wdog_cnt_ff, blink_cnt_ff;
    lio_pkg::lio_state_t state_ff, nxt_state;
    lio_pkg::lio_led_t run_ff, err_ff, nxt_run, nxt_err;

    // ==========================================================
    // Input synchroniser
    lio_in_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({power_good, input_line}),
        .level(sync_lvl),
        .change(sync_chg)
    );
    assign din_chg = sync_chg[lio_pkg::DIN_W-1:0];

    // ==========================================================
    // AXI4-Lite slave, one write and one read at a time
    always_comb begin
        aw_take = s_axi_awvalid & awready_ff;
        w_take = s_axi_wvalid & wready_ff;
        wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;
        ar_take = s_axi_arvalid & arready_ff;
        nxt_aw_hold = (aw_hold_ff | aw_take) & ~wr_go;
        nxt_w_hold = (w_hold_ff | w_take) & ~wr_go;
        nxt_bvalid = wr_go | (bvalid_ff & ~s_axi_bready);
        nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bresp_ff <= lio_pkg::RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            bvalid_ff <= nxt_bvalid;
            // Ready again only after the response has gone
            awready_ff <= ~nxt_aw_hold & ~nxt_bvalid & ~wr_go;
            wready_ff <= ~nxt_w_hold & ~nxt_bvalid & ~wr_go;
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                bresp_ff <= wr_ok ? lio_pkg::RESP_OKAY
                                  : lio_pkg::RESP_SLVERR;
            end
        end
    end

    always_comb begin
        unique case (awaddr_ff)
            lio_pkg::OFS_CTRL, lio_pkg::OFS_DOUT, lio_pkg::OFS_LVL_EN,
            lio_pkg::OFS_LVL_SRC, lio_pkg::OFS_THR_PULSE,
            lio_pkg::OFS_THR_ANALOG, lio_pkg::OFS_THR_ENC,
            lio_pkg::OFS_STAT, lio_pkg::OFS_MASK,
            lio_pkg::OFS_WDOG: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // Software registers
    always_comb begin
        nxt_ctrl = merge(32'(ctrl_ff), wdata_ff, wstrb_ff);
        nxt_dout = merge(32'(dout_ff), wdata_ff, wstrb_ff);
        nxt_mask = merge(32'(mask_ff), wdata_ff, wstrb_ff);
        nxt_lvl_en = merge(32'(lvl_en_ff), wdata_ff, wstrb_ff);
        stat_clr = merge(32'h0000_0000, wdata_ff, wstrb_ff);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= '0;
            dout_ff <= '0;
            lvl_en_ff <= '0;
            lvl_src_ff <= '0;
            thr_pulse_ff <= '0;
            thr_analog_ff <= '0;
            thr_enc_ff <= '0;
            mask_ff <= '0;
        end else if (wr_go) begin
            unique case (awaddr_ff)
                lio_pkg::OFS_CTRL: ctrl_ff <= lio_pkg::lio_ctrl_t'(
                    nxt_ctrl[$bits(lio_pkg::lio_ctrl_t)-1:0]);
                lio_pkg::OFS_DOUT:
                    dout_ff <= nxt_dout[lio_pkg::DIN_W-1:0];
                lio_pkg::OFS_LVL_EN:
                    lvl_en_ff <= nxt_lvl_en[lio_pkg::DIN_W-1:0];
                lio_pkg::OFS_LVL_SRC:
                    lvl_src_ff <= merge(lvl_src_ff, wdata_ff, wstrb_ff);
                lio_pkg::OFS_THR_PULSE:
                    thr_pulse_ff <= merge(thr_pulse_ff, wdata_ff, wstrb_ff);
                lio_pkg::OFS_THR_ANALOG: thr_analog_ff <=
                    merge(thr_analog_ff, wdata_ff, wstrb_ff);
                lio_pkg::OFS_THR_ENC:
                    thr_enc_ff <= merge(thr_enc_ff, wdata_ff, wstrb_ff);
                lio_pkg::OFS_MASK:
                    mask_ff <= nxt_mask[lio_pkg::STAT_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Read path
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr[7:6] == lio_pkg::STAMP_SEL) begin
            rd_word = stamp_ff[s_axi_araddr[5:2]];
        end else begin
            unique case (s_axi_araddr)
                lio_pkg::OFS_CTRL: rd_word = 32'(ctrl_ff);
                lio_pkg::OFS_DIN:
                    rd_word = 32'(sync_lvl[lio_pkg::DIN_W-1:0]);
                lio_pkg::OFS_DOUT: rd_word = 32'(dout_ff);
                lio_pkg::OFS_LVL_EN: rd_word = 32'(lvl_en_ff);
                lio_pkg::OFS_LVL_SRC: rd_word = lvl_src_ff;
                lio_pkg::OFS_THR_PULSE: rd_word = thr_pulse_ff;
                lio_pkg::OFS_THR_ANALOG: rd_word = thr_analog_ff;
                lio_pkg::OFS_THR_ENC: rd_word = thr_enc_ff;
                lio_pkg::OFS_STAT: rd_word = 32'(stat_ff);
                lio_pkg::OFS_MASK: rd_word = 32'(mask_ff);
                lio_pkg::OFS_TIME: rd_word = time_ff;
                lio_pkg::OFS_WDOG: rd_word = 32'(wdog_cnt_ff);
                default: rd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= lio_pkg::RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= ~nxt_rvalid & ~ar_take;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_ok ? lio_pkg::RESP_OKAY
                                  : lio_pkg::RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Time base and edge stamps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            time_ff <= '0;
        end else begin
            time_ff <= time_ff + 32'h0000_0001;
        end
    end

    // Lag removal keeps stamps well inside the microsecond budget
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < lio_pkg::DIN_W; i++) begin
                stamp_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < lio_pkg::DIN_W; i++) begin
                if (din_chg[i]) begin
                    stamp_ff[i] <= time_ff - lio_pkg::SYNC_LAG;
                end
            end
        end
    end

    // ==========================================================
    // Events, sticky status and interrupt
    always_comb begin
        link_fall = link_ff & ~link_alive;
        stat_set = {wdog_fire, link_fall, din_chg};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_ff <= 1'b0;
            stat_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            link_ff <= link_alive;
            // Set beats a clear in the same cycle
            if (wr_go && awaddr_ff == lio_pkg::OFS_STAT) begin
                stat_ff <= (stat_ff & ~stat_clr[lio_pkg::STAT_W-1:0])
                           | stat_set;
            end else begin
                stat_ff <= stat_ff | stat_set;
            end
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    // ==========================================================
    // Output drive
    always_comb begin
        for (int i = 0; i < lio_pkg::DIN_W; i++) begin
            unique case (lio_pkg::lio_src_t'(lvl_src_ff[2*i +: 2]))
                lio_pkg::SRC_PULSE:
                    lvl_hit[i] = at_level(mon_pulse, thr_pulse_ff);
                lio_pkg::SRC_ANALOG:
                    lvl_hit[i] = at_level(mon_analog, thr_analog_ff);
                lio_pkg::SRC_ENC:
                    lvl_hit[i] = at_level(mon_encoder, thr_enc_ff);
                lio_pkg::SRC_NONE: lvl_hit[i] = 1'b0;
            endcase
        end
        if (!link_alive) begin
            cmd_eff = ctrl_ff.hold ? out_ff : '0;
        end else begin
            cmd_eff = dout_ff;
        end
        nxt_out = (lvl_en_ff & lvl_hit) | (~lvl_en_ff & cmd_eff);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    // ==========================================================
    // Life cycle and watchdog
    always_comb begin
        wdog_fire = (state_ff == lio_pkg::ST_RUN) & ctrl_ff.wdog_en
                    & (wdog_cnt_ff == WDOG_CYC - 1'b1);
        nxt_state = state_ff;
        unique case (state_ff)
            lio_pkg::ST_INIT: if (ctrl_ff.init_done) begin
                nxt_state = lio_pkg::ST_RUN;
            end
            lio_pkg::ST_RUN: if (wdog_fire) begin
                nxt_state = lio_pkg::ST_WDOG;
            end
            // Only a reset leaves the watchdog error
            lio_pkg::ST_WDOG: nxt_state = lio_pkg::ST_WDOG;
            default: nxt_state = lio_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= lio_pkg::ST_INIT;
            wdog_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (!ctrl_ff.wdog_en || state_ff != lio_pkg::ST_RUN ||
                (wr_go && awaddr_ff == lio_pkg::OFS_WDOG)) begin
                wdog_cnt_ff <= '0;
            end else if (!wdog_fire) begin
                wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
            end
        end
    end

    // ==========================================================
    // Indicators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
        end else if (blink_cnt_ff == BLINK_CYC - 1'b1) begin
            blink_cnt_ff <= '0;
            blink_ff <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 1'b1;
        end
    end

    always_comb begin
        nxt_run = '{green: 1'b1, red: 1'b0};
        nxt_err = '{green: 1'b0, red: 1'b0};
        if (state_ff == lio_pkg::ST_WDOG) begin
            nxt_run = '{green: 1'b0, red: 1'b1};
            nxt_err = '{green: 1'b0, red: 1'b1};
        end else if (state_ff == lio_pkg::ST_INIT) begin
            nxt_run = '{green: 1'b1, red: 1'b1};
            nxt_err = '{green: 1'b1, red: 1'b1};
        end else begin
            if (ctrl_ff.alarm) begin
                nxt_err.red = 1'b1;
            end else if (ctrl_ff.warn) begin
                nxt_err.red = blink_ff;
            end
        end
        if (!sync_lvl[lio_pkg::DIN_W] && state_ff != lio_pkg::ST_WDOG) begin
            nxt_run = '{green: 1'b0, red: 1'b0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_ff <= '0;
            err_ff <= '0;
        end else begin
            run_ff <= nxt_run;
            err_ff <= nxt_err;
        end
    end

    // ==========================================================
    // Port drive
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign output_line = out_ff;
    assign run_led = run_ff;
    assign err_led = err_ff;
    assign irq = irq_ff;

endmodule // lio_top

// ### test_latching_digital_io_module.sv
// Purpose: Self-checking bench of the latching digital I/O module
// Assumes: Small watchdog and blink counts keep the run short
// Notes: Bus results are matched in order through a queue
`timescale 1ns/1ps
module test_latching_digital_io_module;
    logic aclk = 1'b0, aresetn = 1'b0, power_good = 1'b1, drop = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, hit_r, hit_d, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, link_alive;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, val = 32'h0, rdv, t0, r, k;
    logic [31:0] s_axi_rdata, mon_pulse, mon_analog, mon_encoder;
    logic [1:0] s_axi_bresp, s_axi_rresp, sel = 2'h0;
    logic [15:0] input_line = 16'h0, output_line;
    lio_pkg::lio_led_t run_led, err_led;
    logic [65:0] q[$], e;
    int mismatches = 0, check_count = 0;

    always #12.5 aclk = ~aclk;

    lio_top #(.WDOG_CYC(24'h40), .BLINK_CYC(24'h8)) i_lio_top (.*,
        .s_axi_wstrb(4'hf));
    lio_partner i_lio_partner (.*);

    task automatic chk(input string n, input logic [31:0] x, y);
        check_count++;
        if (y !== x) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, x, y);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] rs);
        q.push_back({rs, 64'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, m,
                      input logic [1:0] rs);
        q.push_back({rs, m, x});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdv = s_axi_rdata;
    endtask

    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            e = q.pop_front();
            chk("bresp", 32'(e[65:64]), 32'(s_axi_bresp));
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = q.pop_front();
            chk("rresp", 32'(e[65:64]), 32'(s_axi_rresp));
            chk("rdata", e[31:0], s_axi_rdata & e[63:32]);
        end
    end

    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hfc73));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("run", 32'(run_led), 32'h3);
        chk("err", 32'(err_led), 32'h3);
        wr(8'h00, 32'h1, 2'h0);
        repeat (3) @(posedge aclk);
        chk("run", 32'(run_led), 32'h2);
        chk("err", 32'(err_led), 32'h0);
        k = {16'h0, 16'($urandom)};
        wr(8'h08, k, 2'h0);
        rd(8'h08, k, 32'hffff, 2'h0);
        chk("out", 32'(output_line), k);
        rd(8'h30, 32'h0, 32'hffffffff, 2'h2);
        wr(8'h04, k, 2'h2);
        wr(8'h24, 32'hffff, 2'h0);
        rd(8'h28, 32'h0, 32'h0, 2'h0);
        t0 = rdv;
        r = {16'h0, 16'($urandom) | 16'h1};
        input_line <= r[15:0];
        repeat (8) @(posedge aclk);
        chk("irq", 32'(irq), 32'h1);
        rd(8'h04, r, 32'hffff, 2'h0);
        rd(8'h20, r, 32'hffff, 2'h0);
        rd(8'h40, 32'h0, 32'h0, 2'h0);
        chk("stamp", 32'(rdv - t0 + 32'h8 < 32'h30), 32'h1);
        wr(8'h20, 32'h3ffff, 2'h0);
        repeat (3) @(posedge aclk);
        chk("irq", 32'(irq), 32'h0);
        drop <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("out", 32'(output_line), 32'h0);
        drop <= 1'b0;
        wr(8'h00, 32'h3, 2'h0);
        drop <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("out", 32'(output_line), k);
        wr(8'h0c, 32'h1, 2'h0);
        for (int s = 1; s < 4; s++) begin
            wr(8'h10, 32'(s), 2'h0);
            wr(8'h10 + 8'(4 * s), 32'h64, 2'h0);
            sel <= 2'(s);
            val <= 32'h64 + ($urandom & 32'hff);
            repeat (3) @(posedge aclk);
            chk("lvl", 32'(output_line[0]), 32'h1);
            val <= 32'h63 - ($urandom & 32'hff);
            repeat (3) @(posedge aclk);
            chk("lvl", 32'(output_line[0]), 32'h0);
        end
        drop <= 1'b0;
        wr(8'h00, 32'h5, 2'h0);
        hit_r = 1'b0;
        hit_d = 1'b0;
        repeat (40) begin
            @(posedge aclk);
            hit_r |= (err_led === 2'b01);
            hit_d |= (err_led === 2'b00);
        end
        chk("flash", 32'({hit_r, hit_d}), 32'h3);
        wr(8'h00, 32'hd, 2'h0);
        repeat (2) begin
            repeat (8) @(posedge aclk);
            chk("err", 32'(err_led), 32'h1);
        end
        power_good <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("run", 32'(run_led), 32'h0);
        power_good <= 1'b1;
        wr(8'h00, 32'h11, 2'h0);
        repeat (80) @(posedge aclk);
        chk("run", 32'(run_led), 32'h1);
        chk("err", 32'(err_led), 32'h1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("run", 32'(run_led), 32'h3);
        chk("err", 32'(err_led), 32'h3);
        stop_test();
    end
endmodule // test_latching_digital_io_module
